//--- rtl/lcg_pkg.sv
// constants, field layout and term decoding for the gate 2/3 input selection
// assumes a 32-bit avalon-mm slave port and one 10 mhz system clock
// Function
// RQ1: gate 2 takes lane 4 true when bit 7 is set and lane 4 inverted when bit 6 is set.
// RQ2: gate 2 takes lane 3 true when bit 5 is set and lane 3 inverted when bit 4 is set.
// RQ3: gate 2 takes lane 2 true when bit 3 is set and lane 2 inverted when bit 2 is set.
// RQ4: gate 2 takes lane 1 true when bit 1 is set and lane 1 inverted when bit 0 is set.
// RQ5: gate 3 takes lane 4 true when bit 7 is set and lane 4 inverted when bit 6 is set.
// RQ6: gate 3 takes lane 3 true when bit 5 is set and lane 3 inverted when bit 4 is set.
// RQ7: gate 3 takes lane 2 true when bit 3 is set and lane 2 inverted when bit 2 is set.
// RQ8: gate 3 takes lane 1 true when bit 1 is set and lane 1 inverted when bit 0 is set.
// RQ9: all enable bits read and write, start undefined at power-on and survive every other reset.
// RQ10: each lane carries the source picked by its own 6-bit selection field.
// RQ11: each gate is the or of its enabled terms and is 0 when none is enabled.
`default_nettype none

package lcg_pkg;

  // bus geometry
  localparam int LCG_ADDR_W = 5;
  localparam int LCG_DATA_W = 32;
  localparam int LCG_BE_W   = 4;
  localparam int LCG_REG_W  = 8;
  localparam int LCG_SEL_W  = 6;
  localparam int LCG_LANES  = 4;
  localparam int LCG_NUM_SRC_DEF = 64;

  // register byte offsets
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_G2_EN = 5'h00;
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_G3_EN = 5'h04;
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_SEL1  = 5'h08;
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_SEL2  = 5'h0c;
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_SEL3  = 5'h10;
  localparam logic [LCG_ADDR_W-1:0] LCG_OFF_SEL4  = 5'h14;

  // decoded register slots
  localparam int LCG_SLOT_G2   = 0;
  localparam int LCG_SLOT_G3   = 1;
  localparam int LCG_SLOT_SEL  = 2;
  localparam int LCG_NUM_SLOTS = 6;

  // enable field positions inside each gate register
  localparam int LCG_D4_TRUE = 7;
  localparam int LCG_D4_INV  = 6;
  localparam int LCG_D3_TRUE = 5;
  localparam int LCG_D3_INV  = 4;
  localparam int LCG_D2_TRUE = 3;
  localparam int LCG_D2_INV  = 2;
  localparam int LCG_D1_TRUE = 1;
  localparam int LCG_D1_INV  = 0;

  // power-on values: contents are undefined, zero is one legal choice
  localparam logic [LCG_REG_W-1:0] LCG_EN_RST  = 8'h00;
  localparam logic [LCG_SEL_W-1:0] LCG_SEL_RST = 6'h00;
  localparam logic [LCG_DATA_W-1:0] LCG_RD_RST = 32'h0000_0000;

  // bus handshake states
  typedef enum logic [1:0] {
    LCG_ST_IDLE = 2'b01,
    LCG_ST_ACK  = 2'b10
  } lcg_bus_state_e;

  // lane k true term at bit 2k+1, inverted term at bit 2k
  function automatic logic [LCG_REG_W-1:0] lcg_term_vector(input logic [LCG_LANES-1:0] lanes);
    logic [LCG_REG_W-1:0] v;
    v = '0;
    for (int k = 0; k < LCG_LANES; k++) begin
      v[2*k+1] = lanes[k];
      v[2*k]   = ~lanes[k];
    end
    return v;
  endfunction

endpackage

`default_nettype wire

//--- rtl/lcg_gate_term.sv
// one gate: or of the enabled true and inverted lane terms
// assumes lanes and enables are settled within the system clock cycle
`default_nettype none

module lcg_gate_term
  import lcg_pkg::*;
(
  input  wire logic [lcg_pkg::LCG_LANES-1:0] lanes,   // selected data lanes
  input  wire logic [lcg_pkg::LCG_REG_W-1:0] enables, // term enable bits
  output logic                               term     // gate result before the output register
);

  // each bit of enables admits exactly one term; none enabled gives 0
  always_comb begin
    term = |(enables & lcg_term_vector(lanes)); // RQ11
  end

endmodule

`default_nettype wire

//--- rtl/lcg_gate23_sel.sv
// gate 2 and gate 3 input selection with its register slave
// assumes avalon-mm master on clk, source inputs synchronous to clk
`default_nettype none

module lcg_gate23_sel
  import lcg_pkg::*;
#(
  parameter int NUM_SRC = lcg_pkg::LCG_NUM_SRC_DEF
) (
  input  wire logic                             clk,               // system clock
  input  wire logic                             rst_n,             // power-on / brown-out reset
  input  wire logic                             warm_rst_n,        // any other reset source
  input  wire logic [lcg_pkg::LCG_ADDR_W-1:0]   avs_address,       // byte address
  input  wire logic                             avs_read,          // read request
  input  wire logic                             avs_write,         // write request
  input  wire logic [lcg_pkg::LCG_DATA_W-1:0]   avs_writedata,     // write data
  input  wire logic [lcg_pkg::LCG_BE_W-1:0]     avs_byteenable,    // byte enables
  output logic      [lcg_pkg::LCG_DATA_W-1:0]   avs_readdata,      // read data
  output logic                                  avs_waitrequest,   // stall
  input  wire logic [NUM_SRC-1:0]               source_in,         // candidate lane sources
  output logic                                  gate2_term,        // gate 2 result
  output logic                                  gate3_term         // gate 3 result
);

  // refuse source counts that the selection field cannot address
  if (NUM_SRC < 1 || NUM_SRC > (1 << LCG_SEL_W)) begin : g_bad_num_src
    $error("NUM_SRC out of range for the selection field");
  end

  localparam logic [LCG_SEL_W:0] SRC_LIMIT = (LCG_SEL_W+1)'(NUM_SRC);

  lcg_bus_state_e         state_q;
  logic [LCG_REG_W-1:0]   gate2_term_enables_q;
  logic [LCG_REG_W-1:0]   gate3_term_enables_q;
  logic [LCG_SEL_W-1:0]   lane_source_select_q [LCG_LANES];
  logic [LCG_LANES-1:0]   lane;
  logic [LCG_NUM_SLOTS-1:0] hit;
  logic                   bus_req;
  logic                   bus_done;
  logic                   wr_commit;
  logic                   gate2_raw;
  logic                   gate3_raw;
  logic [LCG_DATA_W-1:0]  rd_mux;

  // one-hot slot decode, shared by read and write paths
  function automatic logic [LCG_NUM_SLOTS-1:0] slot_decode(input logic [LCG_ADDR_W-1:0] a);
    logic [LCG_NUM_SLOTS-1:0] s;
    s = '0;
    s[LCG_SLOT_G2]    = (a == LCG_OFF_G2_EN);
    s[LCG_SLOT_G3]    = (a == LCG_OFF_G3_EN);
    s[LCG_SLOT_SEL]   = (a == LCG_OFF_SEL1);
    s[LCG_SLOT_SEL+1] = (a == LCG_OFF_SEL2);
    s[LCG_SLOT_SEL+2] = (a == LCG_OFF_SEL3);
    s[LCG_SLOT_SEL+3] = (a == LCG_OFF_SEL4);
    return s;
  endfunction

  // request qualifiers
  assign bus_req   = avs_read | avs_write;
  assign bus_done  = (state_q == LCG_ST_ACK) && bus_req;
  assign hit       = slot_decode(avs_address);
  assign wr_commit = bus_done && avs_write && avs_byteenable[0];

  // handshake: one wait cycle, then the answer; warm reset also clears it
  always_ff @(posedge clk) begin
    if (!rst_n || !warm_rst_n) begin
      state_q         <= LCG_ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (state_q)
        LCG_ST_IDLE: begin
          if (bus_req) begin
            state_q         <= LCG_ST_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        LCG_ST_ACK: begin
          state_q         <= LCG_ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state_q         <= LCG_ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read mux; unmapped offsets and unused upper bits read as zero
  always_comb begin
    rd_mux = '0;
    if (hit[LCG_SLOT_G2]) begin
      rd_mux[LCG_REG_W-1:0] = gate2_term_enables_q;
    end
    if (hit[LCG_SLOT_G3]) begin
      rd_mux[LCG_REG_W-1:0] = gate3_term_enables_q;
    end
    for (int k = 0; k < LCG_LANES; k++) begin
      if (hit[LCG_SLOT_SEL+k]) begin
        rd_mux[LCG_SEL_W-1:0] = lane_source_select_q[k];
      end
    end
  end

  // read data captured as waitrequest drops; nothing can write in between
  always_ff @(posedge clk) begin
    if (!rst_n || !warm_rst_n) begin
      avs_readdata <= LCG_RD_RST;
    end else if (state_q == LCG_ST_IDLE && avs_read) begin
      avs_readdata <= rd_mux; // RQ9
    end
  end

  // gate enables: only power-on reset touches them, warm reset leaves them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate2_term_enables_q <= LCG_EN_RST;
      gate3_term_enables_q <= LCG_EN_RST;
    end else if (wr_commit) begin
      if (hit[LCG_SLOT_G2]) begin
        gate2_term_enables_q <= avs_writedata[LCG_REG_W-1:0]; // RQ9
      end
      if (hit[LCG_SLOT_G3]) begin
        gate3_term_enables_q <= avs_writedata[LCG_REG_W-1:0]; // RQ9
      end
    end
  end

  // per-lane source selection and lane multiplexer
  for (genvar k = 0; k < LCG_LANES; k++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        lane_source_select_q[k] <= LCG_SEL_RST;
      end else if (wr_commit && hit[LCG_SLOT_SEL+k]) begin
        lane_source_select_q[k] <= avs_writedata[LCG_SEL_W-1:0]; // RQ10
      end
    end

    // a selection beyond the implemented sources yields a quiet 0
    always_comb begin
      lane[k] = 1'b0;
      if ({1'b0, lane_source_select_q[k]} < SRC_LIMIT) begin
        lane[k] = source_in[lane_source_select_q[k]]; // RQ10
      end
    end
  end

  // gate 2 terms: lane4 t/n bits 7/6 down to lane1 t/n bits 1/0
  lcg_gate_term u_gate2 (
    .lanes   (lane),                 // RQ1 RQ2 RQ3 RQ4
    .enables (gate2_term_enables_q),
    .term    (gate2_raw)
  );

  // gate 3 uses the same layout, bit 1 included despite its odd label
  lcg_gate_term u_gate3 (
    .lanes   (lane),                 // RQ5 RQ6 RQ7 RQ8
    .enables (gate3_term_enables_q),
    .term    (gate3_raw)
  );

  // registered gate outputs; costs one cycle but keeps outputs glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate2_term <= 1'b0;
      gate3_term <= 1'b0;
    end else begin
      gate2_term <= gate2_raw; // RQ11
      gate3_term <= gate3_raw; // RQ11
    end
  end

  // ------------------------------------------------------------------
  // checks on the gate and register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_g2_d4;
    (gate2_term_enables_q[LCG_D4_TRUE] && lane[3]) || (gate2_term_enables_q[LCG_D4_INV] && !lane[3]);
  endsequence
  sequence s_g2_d3;
    (gate2_term_enables_q[LCG_D3_TRUE] && lane[2]) || (gate2_term_enables_q[LCG_D3_INV] && !lane[2]);
  endsequence
  sequence s_g2_d2;
    (gate2_term_enables_q[LCG_D2_TRUE] && lane[1]) || (gate2_term_enables_q[LCG_D2_INV] && !lane[1]);
  endsequence
  sequence s_g2_d1;
    (gate2_term_enables_q[LCG_D1_TRUE] && lane[0]) || (gate2_term_enables_q[LCG_D1_INV] && !lane[0]);
  endsequence
  sequence s_g3_d4;
    (gate3_term_enables_q[LCG_D4_TRUE] && lane[3]) || (gate3_term_enables_q[LCG_D4_INV] && !lane[3]);
  endsequence
  sequence s_g3_d3;
    (gate3_term_enables_q[LCG_D3_TRUE] && lane[2]) || (gate3_term_enables_q[LCG_D3_INV] && !lane[2]);
  endsequence
  sequence s_g3_d2;
    (gate3_term_enables_q[LCG_D2_TRUE] && lane[1]) || (gate3_term_enables_q[LCG_D2_INV] && !lane[1]);
  endsequence
  sequence s_g3_d1;
    (gate3_term_enables_q[LCG_D1_TRUE] && lane[0]) || (gate3_term_enables_q[LCG_D1_INV] && !lane[0]);
  endsequence

  a_g2_d4_term: assert property (s_g2_d4 |=> gate2_term) // RQ1
    else $error("gate 2 missed an enabled lane 4 term");
  a_g2_d3_term: assert property (s_g2_d3 |=> gate2_term) // RQ2
    else $error("gate 2 missed an enabled lane 3 term");
  a_g2_d2_term: assert property (s_g2_d2 |=> gate2_term) // RQ3
    else $error("gate 2 missed an enabled lane 2 term");
  a_g2_d1_term: assert property (s_g2_d1 |=> gate2_term) // RQ4
    else $error("gate 2 missed an enabled lane 1 term");
  a_g3_d4_term: assert property (s_g3_d4 |=> gate3_term) // RQ5
    else $error("gate 3 missed an enabled lane 4 term");
  a_g3_d3_term: assert property (s_g3_d3 |=> gate3_term) // RQ6
    else $error("gate 3 missed an enabled lane 3 term");
  a_g3_d2_term: assert property (s_g3_d2 |=> gate3_term) // RQ7
    else $error("gate 3 missed an enabled lane 2 term");
  a_g3_d1_term: assert property (s_g3_d1 |=> gate3_term) // RQ8
    else $error("gate 3 missed an enabled lane 1 term");

  a_gate_or_zero: assert property ( // RQ11
    ((gate2_term_enables_q & lcg_term_vector(lane)) == '0) |=> !gate2_term)
    else $error("gate 2 high with no enabled term true");

  a_gate3_or_zero: assert property ( // RQ11
    ((gate3_term_enables_q & lcg_term_vector(lane)) == '0) |=> !gate3_term)
    else $error("gate 3 high with no enabled term true");

  a_warm_keeps_regs: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    !warm_rst_n |=> $stable(gate2_term_enables_q) && $stable(gate3_term_enables_q))
    else $error("enable register changed under warm reset");

  // read-back with one idle edge between: write lands, one idle edge, read taken, data seen one edge later
  a_write_reads_back: assert property ( // RQ9
    (wr_commit && hit[LCG_SLOT_G2]) ##2 (state_q == LCG_ST_IDLE && avs_read && hit[LCG_SLOT_G2] && warm_rst_n)
      |=> avs_readdata[LCG_REG_W-1:0] == $past(avs_writedata[LCG_REG_W-1:0], 3))
    else $error("gate 2 enables did not read back as written");

  a_lane_source_path: assert property ( // RQ10
    (gate2_term_enables_q == 8'h02 && {1'b0, lane_source_select_q[0]} < SRC_LIMIT)
      |=> gate2_term == $past(source_in[lane_source_select_q[0]]))
    else $error("lane 1 does not follow its selected source");

  a_bus_answer_time: assert property (disable iff (!rst_n || !warm_rst_n)
    (state_q == LCG_ST_IDLE && bus_req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not given after exactly one wait cycle");

endmodule

`default_nettype wire

//--- verification/lcg_gate23_sel_tb.sv
// self-checking bench for the gate 2/3 input selection block
// assumes lcg_pkg is compiled first and the design answers avalon-mm with waitrequest
`default_nettype none

module lcg_gate23_sel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lcg_pkg::*;

  logic                  clk;
  logic                  rst_n;
  logic                  warm_rst_n;
  logic [LCG_ADDR_W-1:0] avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [LCG_DATA_W-1:0] avs_writedata;
  logic [LCG_BE_W-1:0]   avs_byteenable;
  logic [LCG_DATA_W-1:0] avs_readdata;
  logic                  avs_waitrequest;
  logic [63:0]           src;
  logic                  gate2_term;
  logic                  gate3_term;
  logic [LCG_DATA_W-1:0] rd;
  logic [5:0]            sel [4];
  logic [7:0]            e2;
  logic [7:0]            e3;
  int                    bad_count;
  int                    checked;

  lcg_gate23_sel #(.NUM_SRC(64)) uut (
    .clk(clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .source_in(src), .gate2_term(gate2_term), .gate3_term(gate3_term)
  );

  // 100 ns period system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one bus transfer; request held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                          output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n == 20) begin
      bad_count++;
      $display("CHECK FAILED waitrequest expected 0 seen stuck");
      conclude();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd_cmp(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, 4'hf, q);
    cmp_word(what, exp, q);
  endtask

  // independent model: or of enabled true and inverted lane terms
  function automatic logic exp_term(input logic [7:0] en, input logic [3:0] ln);
    logic t;
    t = 1'b0;
    for (int k = 0; k < 4; k++) begin
      t = t | (en[2*k+1] & ln[k]) | (en[2*k] & ~ln[k]);
    end
    return t;
  endfunction

  // drive sources, let the registered gate path settle, then compare
  task automatic gate_cmp(input logic [63:0] s, input logic x2, input logic x3);
    @(posedge clk);
    src <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_bit("gate2_term", x2, gate2_term);
    cmp_bit("gate3_term", x3, gate3_term);
  endtask

  initial begin
    rst_n = 1'b0;
    warm_rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    src = 64'h0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    warm_rst_n <= 1'b1;
    // register access, byte-enable gating, unmapped offsets
    wr(LCG_OFF_G2_EN, 32'h0000_00a5);
    rd_cmp("gate2_term_enables", LCG_OFF_G2_EN, 32'h0000_00a5);
    wr(LCG_OFF_G3_EN, 32'h0000_005a);
    bus_xfer(1'b1, LCG_OFF_G2_EN, 32'h0000_00ff, 4'he, rd);
    wr(5'h1c, 32'h0000_00ff);
    rd_cmp("gate2_term_enables", LCG_OFF_G2_EN, 32'h0000_00a5);
    rd_cmp("gate3_term_enables", LCG_OFF_G3_EN, 32'h0000_005a);
    rd_cmp("unmapped", 5'h18, 32'h0);
    wr(LCG_OFF_SEL4, 32'hffff_ffff);
    rd_cmp("lane4_source_select", LCG_OFF_SEL4, 32'h0000_003f);
    // a warm reset must leave the enables untouched
    @(posedge clk);
    warm_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    warm_rst_n <= 1'b1;
    rd_cmp("gate2_term_enables", LCG_OFF_G2_EN, 32'h0000_00a5);
    rd_cmp("gate3_term_enables", LCG_OFF_G3_EN, 32'h0000_005a);
    // lanes 1..4 on sources 0..3, walk every enable bit over all lane patterns
    for (int k = 0; k < 4; k++) wr(LCG_OFF_SEL1 + 5'(4*k), 32'(k));
    for (int b = 0; b < 10; b++) begin
      e2 = (b < 8) ? 8'(1 << b) : ((b == 8) ? 8'h00 : 8'haa);
      e3 = (b < 8) ? 8'(1 << (7 - b)) : ((b == 8) ? 8'h00 : 8'h55);
      wr(LCG_OFF_G2_EN, {24'h0, e2});
      wr(LCG_OFF_G3_EN, {24'h0, e3});
      for (int p = 0; p < 16; p++) gate_cmp({60'h0, 4'(p)}, exp_term(e2, 4'(p)), exp_term(e3, 4'(p)));
    end
    // each lane follows its own source selection field
    sel = '{6'd10, 6'd20, 6'd30, 6'd63};
    for (int k = 0; k < 4; k++) wr(LCG_OFF_SEL1 + 5'(4*k), {26'h0, sel[k]});
    for (int k = 0; k < 4; k++) begin
      wr(LCG_OFF_G2_EN, 32'(1 << (2*k+1)));
      wr(LCG_OFF_G3_EN, 32'(1 << (2*k)));
      gate_cmp(64'h1 << sel[k], 1'b1, 1'b0);
      gate_cmp(~(64'h1 << sel[k]), 1'b0, 1'b1);
    end
    conclude();
  end
endmodule

`default_nettype wire
